// >>> include/acs_pkg.sv
// constants and types shared by the conversion sequencer
package acs_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ACS_ADDR_MODE   = 8'h00; // normal_mode_reg
  localparam logic [7:0] ACS_ADDR_START  = 8'h04; // start_status_reg
  localparam logic [7:0] ACS_ADDR_PRIO   = 8'h08; // priority_control_reg
  localparam logic [7:0] ACS_ADDR_CLK    = 8'h0c; // clock_div_reg, sample_config_reg, mode_select_reg
  localparam logic [7:0] ACS_ADDR_PRES   = 8'h10; // priority_result_reg
  localparam logic [7:0] ACS_ADDR_MONCTL = 8'h14; // monitor_control
  localparam logic [7:0] ACS_ADDR_CMP0   = 8'h18; // compare value, monitor 0
  localparam logic [7:0] ACS_ADDR_CMP1   = 8'h1c; // compare value, monitor 1
  localparam logic [7:0] ACS_ADDR_RES0   = 8'h20; // normal_result_reg 0..7, one word each

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // normal_mode_reg
  localparam int ACS_MODE_SCAN   = 0;
  localparam int ACS_MODE_REP    = 1;
  localparam int ACS_MODE_ITM    = 2;
  localparam int ACS_MODE_RWAIT  = 3;
  localparam int ACS_MODE_TRIGGER_ENABLE   = 4;
  localparam int ACS_MODE_TRIGGER_SEL   = 5;  // two bits, 6:5
  localparam int ACS_MODE_CH     = 8;  // three bits, 10:8
  // start_status_reg
  localparam int ACS_ST_SOFT     = 0;
  localparam int ACS_ST_BUSY     = 1;
  localparam int ACS_ST_END      = 2;
  // priority_control_reg
  localparam int ACS_PR_CH       = 0;  // three bits, 2:0
  localparam int ACS_PR_REQ      = 4;
  localparam int ACS_PR_BUSY     = 5;
  // clock register
  localparam int ACS_CK_SEL      = 0;  // three bits, 2:0
  localparam int ACS_CK_SAMP     = 4;
  localparam int ACS_CK_VREF     = 8;
  // monitor_control, one byte per monitor
  localparam int ACS_MC_CH       = 0;  // three bits
  localparam int ACS_MC_DIR      = 3;
  localparam int ACS_MC_EN       = 4;
  localparam int ACS_MC_HIT      = 5;
  localparam int ACS_MC_STRIDE   = 8;
  // normal_result_reg
  localparam int ACS_RS_OVR      = 14;
  localparam int ACS_RS_VAL      = 15;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [10:0] ACS_MODE_RST  = 11'h000;
  localparam logic [5:0]  ACS_CONV_CLKS = 6'd27; // conversion clocks after sampling
  localparam logic [5:0]  ACS_SAMP_SHRT = 6'd6;
  localparam logic [5:0]  ACS_SAMP_LONG = 6'd12;
  localparam logic [1:0]  ACS_FOUR_LAST = 2'd3;  // fourth conversion of a group of four
  localparam logic [1:0]  ACS_TRIGGER_SEL_TMR  = 2'b01; // timer compare source

  typedef enum logic [1:0] {
    ACS_ST_IDLE = 2'b00,
    ACS_ST_CONV = 2'b01,
    ACS_ST_WAIT = 2'b11
  } acs_state_t;

endpackage

// >>> rtl/acs_sequencer.sv
// conversion sequencer for an eight-input converter, with wishbone registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int RES_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             ext_trigger_pin_i,
  input  wire logic             timer_trigger_i,
  input  wire logic [RES_W-1:0] core_result_i,
  output logic                  core_start_o,
  output logic      [2:0]       core_channel_o,
  output logic                  core_sample_o,
  output logic                  reference_on_o,
  output logic                  conversion_done_irq_o,
  output logic                  priority_irq_o,
  output logic                  monitor_irq_o
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [10:0]      normal_mode_reg;
  logic [2:0]       priority_channel_sel;
  logic [2:0]       conv_clock_sel;
  logic             sample_time_sel;
  logic [RES_W-1:0] priority_result_reg;
  logic [RES_W-1:0] res_data [8];
  logic [7:0]       valid_flag;
  logic [7:0]       overrun_flag;
  logic [1:0]       monitor_enable;
  logic [1:0]       compare_direction;
  logic [1:0]       compare_hit_flag;
  logic [2:0]       monitor_channel_sel [2];
  logic [RES_W-1:0] compare_value [2];
  logic [1:0]       mon_hit;

  acs_state_t       state;
  logic [5:0]       conv_cnt;
  logic             conv_prio;
  logic [2:0]       cur_ch;
  logic             norm_active;
  logic [1:0]       four_cnt;
  logic             prio_pend;
  logic             busy;
  logic             end_flag;
  logic             priority_busy;
  logic [3:0]       div_cnt;
  logic             ext_prev;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       rd;
  logic       res_hit;
  logic [2:0] res_idx;

  assign acc     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr      = acc && wb_we_i;
  assign rd      = acc && !wb_we_i;
  assign res_hit = (wb_adr_i[7:5] == ACS_ADDR_RES0[7:5]) && (wb_adr_i[1:0] == 2'b00);
  assign res_idx = wb_adr_i[4:2];

  // mode fields
  logic       scan_sel;
  logic       repeat_sel;
  logic       irq_timing_sel;
  logic       read_wait_sel;
  logic       trigger_enable;
  logic [1:0] trigger_sel;
  logic [2:0] channel_sel;

  assign scan_sel       = normal_mode_reg[ACS_MODE_SCAN];
  assign repeat_sel     = normal_mode_reg[ACS_MODE_REP];
  assign irq_timing_sel = normal_mode_reg[ACS_MODE_ITM];
  assign read_wait_sel  = normal_mode_reg[ACS_MODE_RWAIT];
  assign trigger_enable = normal_mode_reg[ACS_MODE_TRIGGER_ENABLE];
  assign trigger_sel    = normal_mode_reg[ACS_MODE_TRIGGER_SEL +: 2];
  assign channel_sel    = normal_mode_reg[ACS_MODE_CH +: 3];

  // ----------------------------------------------------------------
  // start sources and priority request
  // ----------------------------------------------------------------
  logic sw_start;
  logic hw_start;
  logic norm_req;
  logic prio_req;
  logic end_clr;

  assign sw_start = wr && wb_sel_i[0] && (wb_adr_i == ACS_ADDR_START) && wb_dat_i[ACS_ST_SOFT];
  // the pin fires on its rising edge; code 00 selects no hardware source
  assign hw_start = trigger_enable && ((trigger_sel == ACS_TRIGGER_SEL_TMR) ? timer_trigger_i :
                    (trigger_sel[1] && ext_trigger_pin_i && !ext_prev));
  assign norm_req = sw_start || hw_start;
  assign prio_req = wr && wb_sel_i[0] && (wb_adr_i == ACS_ADDR_PRIO) && wb_dat_i[ACS_PR_REQ];
  assign end_clr  = wr && wb_sel_i[0] && (wb_adr_i == ACS_ADDR_START) && !wb_dat_i[ACS_ST_END];

  // edge detector for the trigger pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_trigger_pin_i;
    end
  end

  // ----------------------------------------------------------------
  // prescaler and conversion timing
  // ----------------------------------------------------------------
  logic [3:0] div_mask;
  logic       tick;
  logic [5:0] samp_len;
  logic [5:0] conv_len;
  logic       conv_done;

  // divide by 2^sel; codes above four fall back to the slowest rate
  always_comb begin
    unique case (conv_clock_sel)
      3'd0:    div_mask = 4'h0;
      3'd1:    div_mask = 4'h1;
      3'd2:    div_mask = 4'h3;
      3'd3:    div_mask = 4'h7;
      default: div_mask = 4'hf;
    endcase
  end

  assign tick      = ((div_cnt & div_mask) == div_mask);
  assign samp_len  = sample_time_sel ? ACS_SAMP_LONG : ACS_SAMP_SHRT;
  assign conv_len  = ACS_CONV_CLKS + samp_len;
  assign conv_done = (state == ACS_ST_CONV) && tick && (conv_cnt == conv_len - 6'd1);

  // free-running prescaler; the divided rate is a one-cycle enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // normal-sequence completion terms
  // ----------------------------------------------------------------
  logic last_in_group;
  logic end_event;
  logic keep_going;

  // a scan group n covers inputs 0 through n
  assign last_in_group = !scan_sel || (cur_ch == channel_sel);
  assign end_event     = last_in_group &&
                         !(repeat_sel && !scan_sel && irq_timing_sel &&
                           (four_cnt != ACS_FOUR_LAST));
  assign keep_going    = repeat_sel || (scan_sel && !last_in_group);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                 <= ACS_ST_IDLE;
      conv_cnt              <= 6'd0;
      conv_prio             <= 1'b0;
      cur_ch                <= 3'd0;
      norm_active           <= 1'b0;
      four_cnt              <= 2'd0;
      prio_pend             <= 1'b0;
      busy                  <= 1'b0;
      end_flag              <= 1'b0;
      priority_busy         <= 1'b0;
      core_start_o          <= 1'b0;
      core_channel_o        <= 3'd0;
      core_sample_o         <= 1'b0;
      conversion_done_irq_o <= 1'b0;
      priority_irq_o        <= 1'b0;
      priority_result_reg   <= '0;
    end else begin
      core_start_o          <= 1'b0;
      conversion_done_irq_o <= 1'b0;
      priority_irq_o        <= 1'b0;
      if (end_clr) begin
        end_flag <= 1'b0;
      end
      // a new start is only taken while no normal sequence runs
      if (norm_req && !norm_active) begin
        norm_active <= 1'b1;
        cur_ch      <= scan_sel ? 3'd0 : channel_sel;
        four_cnt    <= 2'd0;
      end
      unique case (state)
        ACS_ST_IDLE: begin
          if (prio_pend) begin
            // priority goes first even if a normal start came with it
            state          <= ACS_ST_CONV;
            conv_cnt       <= 6'd0;
            conv_prio      <= 1'b1;
            prio_pend      <= 1'b0;
            core_start_o   <= 1'b1;
            core_channel_o <= priority_channel_sel;
            core_sample_o  <= 1'b1;
          end else if (norm_active) begin
            state          <= ACS_ST_CONV;
            conv_cnt       <= 6'd0;
            conv_prio      <= 1'b0;
            core_start_o   <= 1'b1;
            core_channel_o <= cur_ch;
            core_sample_o  <= 1'b1;
            busy           <= 1'b1;
          end
        end
        ACS_ST_CONV: begin
          if (tick) begin
            conv_cnt <= conv_cnt + 6'd1;
            if (conv_cnt == samp_len - 6'd1) begin
              core_sample_o <= 1'b0;
            end
          end
          if (conv_done) begin
            state <= ACS_ST_IDLE;
            if (conv_prio) begin
              // normal busy and end flag are left alone here
              priority_result_reg <= core_result_i;
              priority_irq_o      <= 1'b1;
              priority_busy       <= 1'b0;
            end else begin
              if (!scan_sel) begin
                four_cnt <= four_cnt + 2'd1;
              end
              if (end_event) begin
                end_flag              <= 1'b1;
                conversion_done_irq_o <= 1'b1;
              end
              if (!keep_going) begin
                norm_active <= 1'b0;
                busy        <= 1'b0;
              end else begin
                // continue with the next channel; a pending priority
                // conversion slips in first from the idle state
                cur_ch <= !scan_sel ? channel_sel :
                          (last_in_group ? 3'd0 : cur_ch + 3'd1);
                if (read_wait_sel && repeat_sel && end_event) begin
                  state <= ACS_ST_WAIT;
                  busy  <= 1'b0;
                end
              end
            end
          end
        end
        ACS_ST_WAIT: begin
          // any normal result read releases the held conversion
          if (!repeat_sel) begin
            state       <= ACS_ST_IDLE;
            norm_active <= 1'b0;
          end else if (rd && res_hit) begin
            state <= ACS_ST_IDLE;
          end
        end
        default: begin
          state <= ACS_ST_IDLE;
        end
      endcase
      // a request in the launching cycle still counts: set wins
      if (prio_req) begin
        prio_pend     <= 1'b1;
        priority_busy <= 1'b1;
      end
      if (conv_done && !conv_prio && end_event && end_clr) begin
        end_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // normal result registers
  // ----------------------------------------------------------------
  logic res_we;

  assign res_we = conv_done && !conv_prio;

  // store and flags per entry; a store in the read cycle keeps its flags
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_res
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          res_data[gi]     <= '0;
          valid_flag[gi]   <= 1'b0;
          overrun_flag[gi] <= 1'b0;
        end else if (res_we && (cur_ch == 3'(gi))) begin
          res_data[gi]     <= core_result_i;
          valid_flag[gi]   <= 1'b1;
          overrun_flag[gi] <= valid_flag[gi];
        end else if (rd && res_hit && (res_idx == 3'(gi))) begin
          valid_flag[gi]   <= 1'b0;
          overrun_flag[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // result monitors
  // ----------------------------------------------------------------
  // compared against the freshly stored value, so the test matches
  // what the monitored register will hold after this edge
  generate
    for (gi = 0; gi < 2; gi++) begin : g_mon
      logic above;
      logic below;
      assign above       = core_result_i > compare_value[gi];
      assign below       = core_result_i < compare_value[gi];
      assign mon_hit[gi] = monitor_enable[gi] && res_we &&
                           (cur_ch == monitor_channel_sel[gi]) &&
                           (compare_direction[gi] ? below : above);
    end
  endgenerate

  // monitor pulse and hit record; a hit beats a clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      monitor_irq_o    <= 1'b0;
      compare_hit_flag <= 2'b00;
    end else begin
      monitor_irq_o <= |mon_hit;
      for (int i = 0; i < 2; i++) begin
        if (mon_hit[i]) begin
          compare_hit_flag[i] <= 1'b1;
        end else if (wr && wb_sel_i[i] && (wb_adr_i == ACS_ADDR_MONCTL) &&
                     wb_dat_i[i*ACS_MC_STRIDE + ACS_MC_HIT]) begin
          compare_hit_flag[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // software-written configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      normal_mode_reg      <= ACS_MODE_RST;
      priority_channel_sel <= 3'd0;
      conv_clock_sel       <= 3'd0;
      sample_time_sel      <= 1'b0;
      reference_on_o       <= 1'b0;
      monitor_enable       <= 2'b00;
      compare_direction    <= 2'b00;
      monitor_channel_sel  <= '{default: 3'd0};
      compare_value        <= '{default: '0};
    end else if (wr) begin
      unique case (wb_adr_i)
        ACS_ADDR_MODE: begin
          if (wb_sel_i[0]) normal_mode_reg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) normal_mode_reg[10:8] <= wb_dat_i[10:8];
        end
        ACS_ADDR_PRIO: begin
          if (wb_sel_i[0]) priority_channel_sel <= wb_dat_i[ACS_PR_CH +: 3];
        end
        ACS_ADDR_CLK: begin
          if (wb_sel_i[0]) conv_clock_sel  <= wb_dat_i[ACS_CK_SEL +: 3];
          if (wb_sel_i[0]) sample_time_sel <= wb_dat_i[ACS_CK_SAMP];
          if (wb_sel_i[1]) reference_on_o  <= wb_dat_i[ACS_CK_VREF];
        end
        ACS_ADDR_MONCTL: begin
          for (int i = 0; i < 2; i++) begin
            if (wb_sel_i[i]) begin
              monitor_channel_sel[i] <= wb_dat_i[i*ACS_MC_STRIDE + ACS_MC_CH +: 3];
              compare_direction[i]   <= wb_dat_i[i*ACS_MC_STRIDE + ACS_MC_DIR];
              monitor_enable[i]      <= wb_dat_i[i*ACS_MC_STRIDE + ACS_MC_EN];
            end
          end
        end
        ACS_ADDR_CMP0: begin
          if (wb_sel_i[1:0] == 2'b11) compare_value[0] <= wb_dat_i[RES_W-1:0];
        end
        ACS_ADDR_CMP1: begin
          if (wb_sel_i[1:0] == 2'b11) compare_value[1] <= wb_dat_i[RES_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------
  logic [31:0] rdata;

  always_comb begin
    rdata = 32'h0000_0000;
    if (res_hit) begin
      rdata[RES_W-1:0]  = res_data[res_idx];
      rdata[ACS_RS_OVR] = overrun_flag[res_idx];
      rdata[ACS_RS_VAL] = valid_flag[res_idx];
    end else begin
      unique case (wb_adr_i)
        ACS_ADDR_MODE:  rdata[10:0] = normal_mode_reg;
        ACS_ADDR_START: begin
          rdata[ACS_ST_BUSY] = busy;
          rdata[ACS_ST_END]  = end_flag;
        end
        ACS_ADDR_PRIO: begin
          rdata[ACS_PR_CH +: 3] = priority_channel_sel;
          rdata[ACS_PR_BUSY]    = priority_busy;
        end
        ACS_ADDR_CLK: begin
          rdata[ACS_CK_SEL +: 3] = conv_clock_sel;
          rdata[ACS_CK_SAMP]     = sample_time_sel;
          rdata[ACS_CK_VREF]     = reference_on_o;
        end
        ACS_ADDR_PRES:  rdata[RES_W-1:0] = priority_result_reg;
        ACS_ADDR_MONCTL: begin
          for (int i = 0; i < 2; i++) begin
            rdata[i*ACS_MC_STRIDE + ACS_MC_CH +: 3] = monitor_channel_sel[i];
            rdata[i*ACS_MC_STRIDE + ACS_MC_DIR]     = compare_direction[i];
            rdata[i*ACS_MC_STRIDE + ACS_MC_EN]      = monitor_enable[i];
            rdata[i*ACS_MC_STRIDE + ACS_MC_HIT]     = compare_hit_flag[i];
          end
        end
        ACS_ADDR_CMP0:  rdata[RES_W-1:0] = compare_value[0];
        ACS_ADDR_CMP1:  rdata[RES_W-1:0] = compare_value[1];
        default:        rdata = 32'h0000_0000;
      endcase
    end
  end

  // one wait state; unmapped addresses still answer, reading zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rdata : 32'h0000_0000;
    end
  end

endmodule

// >>> sim/acs_core_model.sv
// behavioural converter core facing the sequencer
`timescale 1ns/1ps
module acs_core_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [2:0] channel_i,
  output logic      [9:0] result_o
);
  initial result_o = 10'h000;
  // result encodes its channel so a misrouted store cannot pass
  always @(posedge clk_i) if (start_i) result_o <= {channel_i, 4'h9, channel_i};
endmodule

// >>> sim/acs_asserts.sv
// port timing checker for the conversion sequencer
`timescale 1ns/1ps
module acs_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        core_start_o,
  input wire logic        core_sample_o,
  input wire logic        conversion_done_irq_o,
  input wire logic        priority_irq_o,
  input wire logic        monitor_irq_o
);
  int gap;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles since last launch; starts saturated so the first launch is free
  always_ff @(posedge clk_i) begin
    if (rst_i) gap <= 99;
    else if (core_start_o) gap <= 0;
    else if (gap < 99) gap <= gap + 1;
  end
  chk_ack_slot: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
  chk_done_pulse: assert property (conversion_done_irq_o |=> !conversion_done_irq_o)
    else $error("done irq held");
  chk_prio_pulse: assert property (priority_irq_o |=> !priority_irq_o)
    else $error("prio irq held");
  chk_mon_pulse: assert property (monitor_irq_o |=> !monitor_irq_o)
    else $error("monitor irq held");
  chk_samp_len: assert property ($rose(core_sample_o) |-> core_sample_o[*5])
    else $error("sampling short");
  chk_conv_gap: assert property (core_start_o |-> gap >= 32) else $error("launch early");
  cover property (conversion_done_irq_o);
  cover property (priority_irq_o);
  cover property (monitor_irq_o);
endmodule
bind acs_sequencer acs_asserts u_acs_asserts (.*);

// >>> sim/tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_top
  import acs_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, seed = 24134, wb_dat_o, q;
  logic        wb_ack_o, c_st, c_smp, ref_on, d_irq, p_irq, m_irq;
  logic        pin = 0, tmr = 0;
  logic [2:0]  c_ch, ch, p;
  logic [9:0]  c_res;
  logic [2:0]  chq[$];
  int          error_cnt = 0, checks_done = 0, n_d = 0, n_p = 0, n_m = 0, cyc_n = 0, s0;
  int          t0 = 0, dt = 0, cl;
  always #2.5 clk_i = ~clk_i;
  acs_sequencer u_acs_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_trigger_pin_i(pin), .timer_trigger_i(tmr),
    .core_result_i(c_res), .core_start_o(c_st), .core_channel_o(c_ch), .core_sample_o(c_smp),
    .reference_on_o(ref_on), .conversion_done_irq_o(d_irq), .priority_irq_o(p_irq),
    .monitor_irq_o(m_irq));
  acs_core_model u_acs_core_model (.clk_i(clk_i), .start_i(c_st), .channel_i(c_ch),
    .result_o(c_res));
  // tally on the falling edge, where outputs are settled; also the hang limit
  always @(negedge clk_i) begin
    n_d += (d_irq === 1'b1);
    n_p += (p_irq === 1'b1);
    n_m += (m_irq === 1'b1);
    if (c_st === 1'b1) chq.push_back(c_ch);
    if (c_st === 1'b1) t0 = cyc_n;
    if (d_irq === 1'b1) dt = cyc_n - t0;
    if (++cyc_n == 30000) begin
      error_cnt++;
      results();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] res_of(input logic [2:0] c);
    return {c, 4'h9, c};
  endfunction
  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle; the next call lets an edge pass before raising stb
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic waitc(ref int c, input int k);
    for (int n = 0; c < k && n < 5000; n++) @(posedge clk_i);
  endtask
  task results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, ACS_ADDR_MODE, 0);
    chk(q, 0, "mode reset");
    bus(0, 8'hfc, 0);
    chk(q, 0, "unmapped read");
    bus(1, ACS_ADDR_CLK, 32'h104);
    chk(ref_on, 1, "reference on");
    $display("test reset done");
    // fixed single on a random channel, then clear end by writing 0
    ch = 3'(xs());
    bus(1, ACS_ADDR_MODE, {21'h0, ch, 8'h00});
    bus(1, ACS_ADDR_START, 5);
    waitc(n_d, 1);
    chk(chq[$], ch, "fixed channel");
    bus(0, ACS_ADDR_START, 0);
    chk(q[2:1], 2'b10, "end set busy clear");
    bus(0, ACS_ADDR_RES0 + {3'h0, ch, 2'b00}, 0);
    chk({q[15], q[9:0]}, {1'b1, res_of(ch)}, "result slot");
    bus(1, ACS_ADDR_START, 0);
    bus(0, ACS_ADDR_START, 0);
    chk(q[2], 0, "end cleared");
    $display("test fixed single done");
    // group three scan, priority request mid-conversion, both monitors armed
    p = 3'(xs());
    bus(1, ACS_ADDR_CMP1, 32'h3ff);
    bus(1, ACS_ADDR_MONCTL, 32'h1912);
    s0 = chq.size();
    bus(1, ACS_ADDR_MODE, 32'h301);
    bus(1, ACS_ADDR_START, 5);
    bus(1, ACS_ADDR_PRIO, {27'h0, 2'b10, p});
    waitc(n_d, 2);
    chk(n_p, 1, "priority pulses");
    chk(chq.size() - s0, 5, "launch count");
    chk({chq[s0], chq[s0+1], chq[s0+2], chq[s0+3], chq[s0+4]}, {3'd0, p, 9'o123}, "order");
    bus(0, ACS_ADDR_PRES, 0);
    chk(q[9:0], res_of(p), "priority result");
    bus(0, ACS_ADDR_MONCTL, 0);
    chk({n_m[7:0], q[13], q[5]}, {8'd2, 2'b11}, "monitor hits");
    bus(1, ACS_ADDR_MONCTL, 0);
    $display("test scan priority done");
    // every fourth result ends in fixed continuous, then repeat is dropped
    ch = 3'(xs());
    bus(1, ACS_ADDR_MODE, {21'h0, ch, 8'h06});
    bus(1, ACS_ADDR_START, 1);
    waitc(n_d, 3);
    s0 = chq.size();
    waitc(n_d, 4);
    chk(chq.size() - s0, 4, "launches per end");
    bus(1, ACS_ADDR_MODE, {21'h0, ch, 8'h04});
    s0 = chq.size();
    bus(0, ACS_ADDR_START, 0);
    for (int i = 0; i < 300 && q[1] !== 1'b0; i++) bus(0, ACS_ADDR_START, 0);
    chk({q[1], 1'(chq.size() - s0 < 2)}, 2'b01, "stop after current");
    $display("test continuous done");
    // timer-started scan continuous with read wait, released by a result read
    bus(1, ACS_ADDR_MODE, 32'h13b);
    @(posedge clk_i) tmr <= 1'b1;
    @(posedge clk_i) tmr <= 1'b0;
    waitc(n_d, n_d + 1);
    s0 = chq.size();
    repeat (600) @(posedge clk_i);
    chk(chq.size() - s0, 0, "read wait holds");
    bus(0, ACS_ADDR_RES0, 0);
    waitc(n_d, n_d + 1);
    chk(chq.size() - s0, 2, "group rescanned");
    bus(1, ACS_ADDR_MODE, 0);
    $display("test read wait done");
    // pin-started fixed single, long sampling; length in clock cycles, 16 per divided tick
    ch = 3'(xs());
    cl = 16 * (ACS_CONV_CLKS + ACS_SAMP_LONG);
    bus(1, ACS_ADDR_CLK, 32'h114);
    bus(1, ACS_ADDR_MODE, {21'h0, ch, 8'h50});
    @(posedge clk_i) pin <= 1'b1;
    waitc(n_d, n_d + 1);
    chk(chq[$], ch, "pin start channel");
    chk(1'(dt inside {[cl - 15 : cl]}), 1, "conversion length");
    bus(1, ACS_ADDR_CLK, 32'h014);
    chk(ref_on, 0, "reference off");
    $display("test trigger timing done");
    results();
  end
endmodule
